// ### rtl/tkdt_params.svh
// constants for the touch key detect and tracking block
`ifndef TKDT_PARAMS_SVH
`define TKDT_PARAMS_SVH

// ************************************
// threshold, drift, confirmation and recalibration delay defaults
// ************************************
`define TKDT_THR_OFFSET      8'h04
`define TKDT_NEG_THRESHOLD_SETTING_DEF        8'h06
`define TKDT_POS_THRESHOLD_SETTING_DEF        8'h02
`define TKDT_DDRIFT_DEF      8'h0A
`define TKDT_UDRIFT_DEF      8'h04
`define TKDT_NORMAL_CONFIRM_LIMIT_DEF        8'h02
`define TKDT_FAST_CONFIRM_LIMIT_DEF        4'h5
`define TKDT_NRD_DEF         8'h14
`define TKDT_PRD_DEF         8'h06

// ************************************
// timing
// ************************************
`define TKDT_CLK_MHZ         250
`define TKDT_TICK_MS         50
`define TKDT_TICK_CYCLES     (`TKDT_TICK_MS * 1000 * `TKDT_CLK_MHZ)
`define TKDT_NRD_UNIT_MS     500
`define TKDT_DDRIFT_UNIT_MS  250

// ************************************
// register map
// ************************************
`define TKDT_REG_CTRL        12'h000
`define TKDT_REG_ACTIVE      12'h004
`define TKDT_REG_SCAN        12'h008
`define TKDT_KEY_AREA        4'h1
`define TKDT_KEY_CFG0        4'h0
`define TKDT_KEY_CFG1        4'h4
`define TKDT_KEY_STAT        4'h8
`define TKDT_CTRL_EN_BIT     0
`define TKDT_CTRL_RECAL_BIT  1
`define TKDT_CTRL_KEY_LSB    8

`endif

// ### rtl/tkdt_pkg.sv
// types shared by the touch key detect and tracking block
package tkdt_pkg;

  typedef struct packed {
    logic [7:0] up_drift_rate;
    logic [7:0] down_drift_rate;
    logic [7:0] pos_threshold_setting;
    logic [7:0] neg_threshold_setting;
  } tkdt_cfg0_t;

  typedef struct packed {
    logic [7:0] pos_recal_delay;
    logic [7:0] neg_recal_delay;
    logic [3:0] rsvd;
    logic [3:0] fast_confirm_limit;
    logic [7:0] normal_confirm_limit;
  } tkdt_cfg1_t;

  typedef struct packed {
    logic [15:0] ref_val;
    logic [3:0]  fast_di;
    logic [7:0]  norm_di;
    logic        active;
    logic        pos_seen;
    logic [15:0] drift_stamp;
    logic [15:0] neg_stamp;
    logic [15:0] pos_stamp;
  } tkdt_key_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_EVAL
  } tkdt_state_t;

endpackage

// ### rtl/tkdt_key_eval.sv
// threshold compare and time translation for the key being evaluated
`timescale 1ns/1ps
`include "tkdt_params.svh"

module tkdt_key_eval (
  input  wire tkdt_pkg::tkdt_cfg0_t cfg0,
  input  wire tkdt_pkg::tkdt_cfg1_t cfg1,
  input  wire logic [15:0] ref_val,
  input  wire logic [15:0] sig,
  output logic             below,
  output logic             above,
  output logic [15:0]      up_ticks,
  output logic [15:0]      down_ticks,
  output logic [15:0]      nrd_ticks,
  output logic [15:0]      prd_ticks
);

  localparam logic [15:0] NRD_MUL = 16'(`TKDT_NRD_UNIT_MS / `TKDT_TICK_MS);
  localparam logic [15:0] DDR_MUL = 16'(`TKDT_DDRIFT_UNIT_MS / `TKDT_TICK_MS);

  logic [16:0] neg_gap;
  logic [16:0] pos_lvl;

  // up drift codes go through a table, in 50 ms ticks
  function automatic logic [15:0] up_lut(input logic [7:0] c);
    case (c)
      8'h00:   up_lut = 16'h0002;
      8'h01:   up_lut = 16'h0004;
      8'h02:   up_lut = 16'h0006;
      8'h03:   up_lut = 16'h0008;
      8'h04:   up_lut = 16'h000C;
      8'h05:   up_lut = 16'h0010;
      8'h06:   up_lut = 16'h0014;
      8'h07:   up_lut = 16'h001E;
      default: up_lut = 16'h0028;
    endcase
  endfunction

  function automatic logic [15:0] prd_lut(input logic [7:0] c);
    case (c)
      8'h00:   prd_lut = 16'h0002;
      8'h01:   prd_lut = 16'h0004;
      8'h02:   prd_lut = 16'h0006;
      8'h03:   prd_lut = 16'h0008;
      8'h04:   prd_lut = 16'h000A;
      8'h05:   prd_lut = 16'h000E;
      8'h06:   prd_lut = 16'h0014;
      8'h07:   prd_lut = 16'h001E;
      8'h08:   prd_lut = 16'h0028;
      default: prd_lut = 16'h003C;
    endcase
  endfunction

  always_comb begin
    neg_gap    = {9'h000, cfg0.neg_threshold_setting} + {9'h000, `TKDT_THR_OFFSET};
    below      = ({1'b0, sig} + neg_gap) <= {1'b0, ref_val};
    pos_lvl    = {1'b0, ref_val} + {9'h000, cfg0.pos_threshold_setting}
               + {9'h000, `TKDT_THR_OFFSET};
    above      = {1'b0, sig} > pos_lvl;
    up_ticks   = up_lut(cfg0.up_drift_rate);
    down_ticks = 16'({8'h00, cfg0.down_drift_rate} * DDR_MUL);
    nrd_ticks  = 16'({8'h00, cfg1.neg_recal_delay} * NRD_MUL);
    prd_ticks  = prd_lut(cfg1.pos_recal_delay);
  end

endmodule

// ### rtl/tkdt_touch_key_detect_tracker.sv
// per key touch detection, drift tracking and recalibration with a wishbone slave
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "tkdt_params.svh"

// Operation
// - negative threshold is reference minus setting minus four
// - thresholds recomputed whenever reference moves
// - positive threshold is reference plus setting plus four
// - drift only without detection or negative crossing
// - separate up and down drift rates
// - down drift default 10, up default 4
// - lock and repeat burst until fast limit
// - fast counter up at threshold, else cleared
// - normal counter once per scan, then active
// - fast limit one means one burst per scan
// - defaults normal limit 2, fast limit 5
// - recalibrate after long continuous detection
// - negative delay byte, half second units, default 20
// - zero negative delay disables auto recalibration
// - recalibrate after positive excursion, default 6
// - detection resumes after any recalibration
// - negative threshold held per key
module tkdt_touch_key_detect_tracker #(
  parameter int NKEYS       = 16,
  parameter int TICK_CYCLES = `TKDT_TICK_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [11:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  output logic                          burst_req,
  output logic [$clog2(NKEYS)-1:0]      burst_key,
  output logic                          burst_repeat,
  input  wire logic                     acq_valid,
  input  wire logic [15:0]              acq_signal,
  output logic [NKEYS-1:0]              key_active
);

  localparam int KW = $clog2(NKEYS);

  // ************************************
  // state
  // ************************************
  tkdt_pkg::tkdt_cfg0_t   cfg0_q [NKEYS];
  tkdt_pkg::tkdt_cfg0_t   cfg0_d [NKEYS];
  tkdt_pkg::tkdt_cfg1_t   cfg1_q [NKEYS];
  tkdt_pkg::tkdt_cfg1_t   cfg1_d [NKEYS];
  tkdt_pkg::tkdt_key_t    st_q   [NKEYS];
  tkdt_pkg::tkdt_key_t    st_d   [NKEYS];
  tkdt_pkg::tkdt_state_t  state_q;
  tkdt_pkg::tkdt_state_t  state_d;
  tkdt_pkg::tkdt_key_t    ks;
  logic [NKEYS-1:0]       pend_q;
  logic [NKEYS-1:0]       pend_d;
  logic [KW-1:0]          key_q;
  logic [KW-1:0]          key_d;
  logic                   rep_q;
  logic                   rep_d;
  logic [15:0]            sig_q;
  logic [15:0]            sig_d;
  logic                   en_q;
  logic                   en_d;
  logic                   ack_q;
  logic                   ack_d;
  logic [31:0]            rdat_q;
  logic [31:0]            rdat_d;
  logic [31:0]            tick_cnt_q;
  logic [31:0]            tick_cnt_d;
  logic [15:0]            now_q;
  logic [15:0]            now_d;
  logic                   below;
  logic                   above;
  logic [15:0]            up_ticks;
  logic [15:0]            down_ticks;
  logic [15:0]            nrd_ticks;
  logic [15:0]            prd_ticks;
  logic                   recal;
  logic [4:0]             fast_inc;
  logic                   advance;
  logic [KW-1:0]          rkey;
  logic [KW-1:0]          wkey;

  function automatic logic [KW-1:0] key_of(input logic [11:0] a);
    key_of = KW'(a[11:4] - 8'h10);
  endfunction

  function automatic logic key_hit(input logic [11:0] a);
    key_hit = (a[11:8] == `TKDT_KEY_AREA) && (int'(a[7:4]) < NKEYS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = n[8*b +: 8];
      end
    end
  endfunction

  tkdt_key_eval u_eval (
    .cfg0       (cfg0_q[key_q]),
    .cfg1       (cfg1_q[key_q]),
    .ref_val    (st_q[key_q].ref_val),
    .sig        (sig_q),
    .below      (below),
    .above      (above),
    .up_ticks   (up_ticks),
    .down_ticks (down_ticks),
    .nrd_ticks  (nrd_ticks),
    .prd_ticks  (prd_ticks)
  );

  // ************************************
  // time base
  // ************************************
  // a coarse tick lets each key keep stamps instead of running counters
  always_comb begin
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    now_d      = now_q;
    if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      now_d      = now_q + 16'h0001;
    end
  end

  // ************************************
  // scan, detect and track
  // ************************************
  always_comb begin
    st_d     = st_q;
    pend_d   = pend_q;
    state_d  = state_q;
    key_d    = key_q;
    rep_d    = rep_q;
    sig_d    = sig_q;
    ks       = st_q[key_q];
    fast_inc = {1'b0, ks.fast_di} + 5'h01;
    advance  = 1'b0;
    // long detection; zero delay never times out; positive excursion
    recal    = pend_q[key_q]
             | (ks.active && (nrd_ticks != 16'h0000) && ((now_q - ks.neg_stamp) > nrd_ticks))
             | (ks.pos_seen && above && ((now_q - ks.pos_stamp) >= prd_ticks));
    case (state_q)
      tkdt_pkg::ST_IDLE: begin
        if (en_q) begin
          state_d = tkdt_pkg::ST_REQ;
        end
      end
      tkdt_pkg::ST_REQ: begin
        if (acq_valid) begin
          sig_d   = acq_signal;
          state_d = tkdt_pkg::ST_EVAL;
        end
      end
      tkdt_pkg::ST_EVAL: begin
        if (recal) begin
          // restart from the present signal; detection free again
          ks.ref_val     = sig_q;
          ks.fast_di     = 4'h0;
          ks.norm_di     = 8'h00;
          ks.active      = 1'b0;
          ks.pos_seen    = 1'b0;
          ks.drift_stamp = now_q;
          ks.neg_stamp   = now_q;
          ks.pos_stamp   = now_q;
          pend_d[key_q]  = 1'b0;
          advance        = 1'b1;
        end else begin
          if (below) begin
            if (fast_inc >= {1'b0, cfg1_q[key_q].fast_confirm_limit}) begin
              // one normal count per visit, so once per scan
              ks.fast_di = 4'h0;
              if (ks.norm_di < cfg1_q[key_q].normal_confirm_limit) begin
                ks.norm_di = ks.norm_di + 8'h01;
              end
              if (!ks.active && (ks.norm_di >= cfg1_q[key_q].normal_confirm_limit)) begin
                ks.active    = 1'b1;
                ks.neg_stamp = now_q;
              end
              // a limit of one never locks
              advance = 1'b1;
            end else begin
              // stay on this key and burst again
              ks.fast_di = fast_inc[3:0];
            end
            ks.drift_stamp = now_q;
          end else begin
            // no tracking on the visit that ends a detection; rate by direction
            if (ks.active) begin
              ks.drift_stamp = now_q;
            end else if (sig_q > ks.ref_val) begin
              if ((now_q - ks.drift_stamp) >= up_ticks) begin
                ks.ref_val     = ks.ref_val + 16'h0001;
                ks.drift_stamp = now_q;
              end
            end else if (sig_q < ks.ref_val) begin
              if ((now_q - ks.drift_stamp) >= down_ticks) begin
                ks.ref_val     = ks.ref_val - 16'h0001;
                ks.drift_stamp = now_q;
              end
            end else begin
              ks.drift_stamp = now_q;
            end
            ks.fast_di = 4'h0;
            ks.norm_di = 8'h00;
            ks.active  = 1'b0;
            advance    = 1'b1;
          end
          if (above) begin
            if (!ks.pos_seen) begin
              ks.pos_seen  = 1'b1;
              ks.pos_stamp = now_q;
            end
          end else begin
            ks.pos_seen = 1'b0;
          end
        end
        st_d[key_q] = ks;
        rep_d       = !advance;
        if (advance) begin
          key_d = (int'(key_q) == NKEYS - 1) ? '0 : key_q + KW'(1);
        end
        state_d = en_q ? tkdt_pkg::ST_REQ : tkdt_pkg::ST_IDLE;
      end
      default: begin
        state_d = tkdt_pkg::ST_IDLE;
      end
    endcase
    // host recal request after the clear, so a new request is never lost
    if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && (wb_adr_i == `TKDT_REG_CTRL)
        && wb_sel_i[1] && wb_dat_i[`TKDT_CTRL_RECAL_BIT]
        && (int'(wb_dat_i[`TKDT_CTRL_KEY_LSB +: 8]) < NKEYS)) begin
      pend_d[KW'(wb_dat_i[`TKDT_CTRL_KEY_LSB +: 8])] = 1'b1;
    end
  end

  // ************************************
  // wishbone slave
  // ************************************
  // write lands on the edge that the master samples ack
  always_comb begin
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    en_d   = en_q;
    rdat_d = rdat_q;
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rkey   = key_of(wb_adr_i);
    wkey   = key_of(wb_adr_i);
    if (ack_d) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == `TKDT_REG_CTRL) begin
        rdat_d[`TKDT_CTRL_EN_BIT] = en_q;
      end else if (wb_adr_i == `TKDT_REG_ACTIVE) begin
        rdat_d = 32'(key_active);
      end else if (wb_adr_i == `TKDT_REG_SCAN) begin
        rdat_d = {22'h000000, rep_q, 1'b0, 8'(key_q)};
      end else if (key_hit(wb_adr_i)) begin
        case (wb_adr_i[3:0])
          `TKDT_KEY_CFG0: rdat_d = cfg0_q[rkey];
          `TKDT_KEY_CFG1: rdat_d = cfg1_q[rkey];
          `TKDT_KEY_STAT: rdat_d = {st_q[rkey].norm_di, 7'h00, st_q[rkey].active,
                                    st_q[rkey].ref_val};
          default:        rdat_d = 32'h0000_0000;
        endcase
      end
    end
    if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i) begin
      if ((wb_adr_i == `TKDT_REG_CTRL) && wb_sel_i[0]) begin
        en_d = wb_dat_i[`TKDT_CTRL_EN_BIT];
      end else if (key_hit(wb_adr_i) && (wb_adr_i[3:0] == `TKDT_KEY_CFG0)) begin
        // each key owns its threshold settings
        cfg0_d[wkey] = merge(cfg0_q[wkey], wb_dat_i, wb_sel_i);
      end else if (key_hit(wb_adr_i) && (wb_adr_i[3:0] == `TKDT_KEY_CFG1)) begin
        cfg1_d[wkey] = merge(cfg1_q[wkey], wb_dat_i, wb_sel_i);
        cfg1_d[wkey].rsvd = 4'h0;
      end
    end
  end

  // ************************************
  // registers
  // ************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < NKEYS; k++) begin
        cfg0_q[k] <= {`TKDT_UDRIFT_DEF, `TKDT_DDRIFT_DEF, `TKDT_POS_THRESHOLD_SETTING_DEF, `TKDT_NEG_THRESHOLD_SETTING_DEF};
        cfg1_q[k] <= {`TKDT_PRD_DEF, `TKDT_NRD_DEF, 4'h0, `TKDT_FAST_CONFIRM_LIMIT_DEF, `TKDT_NORMAL_CONFIRM_LIMIT_DEF};
        st_q[k]   <= '0;
      end
      pend_q     <= '1;
      state_q    <= tkdt_pkg::ST_IDLE;
      key_q      <= '0;
      rep_q      <= 1'b0;
      sig_q      <= 16'h0000;
      en_q       <= 1'b1;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      tick_cnt_q <= 32'h0000_0000;
      now_q      <= 16'h0000;
    end else begin
      cfg0_q     <= cfg0_d;
      cfg1_q     <= cfg1_d;
      st_q       <= st_d;
      pend_q     <= pend_d;
      state_q    <= state_d;
      key_q      <= key_d;
      rep_q      <= rep_d;
      sig_q      <= sig_d;
      en_q       <= en_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
      tick_cnt_q <= tick_cnt_d;
      now_q      <= now_d;
    end
  end

  for (genvar g = 0; g < NKEYS; g++) begin : g_act
    assign key_active[g] = st_q[g].active;
  end

  assign burst_req    = (state_q == tkdt_pkg::ST_REQ);
  assign burst_key    = key_q;
  assign burst_repeat = rep_q;
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;

  // ************************************
  // assertions
  // ************************************
  wire        in_eval = (state_q == tkdt_pkg::ST_EVAL);
  wire [16:0] neg_threshold_setting_c  = {9'h000, cfg0_q[key_q].neg_threshold_setting} + 17'h00004;
  wire [16:0] pos_threshold_setting_c  = {9'h000, cfg0_q[key_q].pos_threshold_setting} + 17'h00004;

  sequence s_waiting;
    burst_req && !acq_valid;
  endsequence

  a_neg_thr_level: assert property (@(posedge clock) disable iff (!resetn)
    in_eval |-> (below == (({1'b0, sig_q} + neg_threshold_setting_c) <= {1'b0, st_q[key_q].ref_val})))
    else $error("negative threshold compare wrong");
  a_pos_thr_level: assert property (@(posedge clock) disable iff (!resetn)
    in_eval |-> (above == ({1'b0, sig_q} > ({1'b0, st_q[key_q].ref_val} + pos_threshold_setting_c))))
    else $error("positive threshold compare wrong");
  a_drift_frozen: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && !recal && (below || st_q[key_q].active)
    |-> st_d[key_q].ref_val == st_q[key_q].ref_val)
    else $error("reference moved during detection");
  a_drift_slew: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && !recal |-> (st_d[key_q].ref_val - st_q[key_q].ref_val == 16'h0001)
      || (st_q[key_q].ref_val - st_d[key_q].ref_val <= 16'h0001))
    else $error("reference slewed more than one count");
  a_fast_lock: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && !recal && below && (fast_inc < {1'b0, cfg1_q[key_q].fast_confirm_limit})
    |=> (key_q == $past(key_q)) && burst_repeat ##1 burst_req)
    else $error("fast burst lock lost");
  a_fast_clear: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && !below |-> st_d[key_q].fast_di == 4'h0)
    else $error("fast counter not cleared");
  a_active_gate: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && st_d[key_q].active && !st_q[key_q].active
    |-> st_d[key_q].norm_di >= cfg1_q[key_q].normal_confirm_limit)
    else $error("key active before normal limit");
  a_recal_reset: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && recal |=> (st_q[$past(key_q)].ref_val == $past(sig_q))
      && !st_q[$past(key_q)].active && (st_q[$past(key_q)].fast_di == 4'h0))
    else $error("recalibration did not reset key");
  a_nrd_off: assert property (@(posedge clock) disable iff (!resetn)
    in_eval && !pend_q[key_q] && !above && (cfg1_q[key_q].neg_recal_delay == 8'h00)
    |-> !recal)
    else $error("recalibration with zero negative delay");
  a_req_held: assert property (@(posedge clock) disable iff (!resetn)
    s_waiting |=> burst_req && (burst_key == $past(burst_key)))
    else $error("burst request dropped before result");
  a_wb_ack: assert property (@(posedge clock) disable iff (!resetn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle");

endmodule

// ### sim/tkdt_front_model.sv
// burst acquisition front-end model answering each request after a set wait
`timescale 1ns/1ps
module tkdt_front_model #(
  parameter int NK = 4
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  burst_req,
  input  wire logic [$clog2(NK)-1:0] burst_key,
  input  wire logic                  burst_repeat,
  input  wire logic [NK*16-1:0]      sigs,
  input  wire logic [3:0]            delay,
  output logic                       acq_valid,
  output logic [15:0]                acq_signal,
  output int                         reps
);
  logic [3:0] cnt_q;
  // result is held only in its valid cycle, so a late sample shows junk
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acq_valid <= 1'b0;
      acq_signal <= 16'h0000;
      cnt_q <= 4'h0;
      reps <= 0;
    end else if (acq_valid) begin
      acq_valid <= 1'b0;
      acq_signal <= ~acq_signal;
      cnt_q <= 4'h0;
    end else if (burst_req && cnt_q >= delay) begin
      acq_valid <= 1'b1;
      acq_signal <= sigs[burst_key*16 +: 16];
      reps <= reps + (burst_repeat ? 1 : 0);
    end else if (burst_req) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ### sim/test_touch_key_detect_tracker.sv
// self-checking bench for the touch key detect and tracking block
`timescale 1ns/1ps
module test_touch_key_detect_tracker;
  logic        clock, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [11:0] wb_adr;
  logic [3:0]  wb_sel, key_active, delay;
  logic [31:0] wb_dat, wb_rdata, q;
  logic        burst_req, burst_repeat, acq_valid;
  logic [1:0]  burst_key;
  logic [15:0] acq_signal;
  logic [63:0] sigs;
  int          reps, r0, k, err_count, compares;
  int          base[4];
  int          ref_m[4];

  always #2 clock = ~clock;

  tkdt_touch_key_detect_tracker #(.NKEYS(4), .TICK_CYCLES(4)) uut (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdata), .wb_ack_o(wb_ack), .burst_req(burst_req),
    .burst_key(burst_key), .burst_repeat(burst_repeat), .acq_valid(acq_valid),
    .acq_signal(acq_signal), .key_active(key_active));
  tkdt_front_model #(.NK(4)) far_end (
    .clock(clock), .resetn(resetn), .burst_req(burst_req), .burst_key(burst_key),
    .burst_repeat(burst_repeat), .sigs(sigs), .delay(delay),
    .acq_valid(acq_valid), .acq_signal(acq_signal), .reps(reps));

  // ************************************
  // bus and compare helpers
  // ************************************
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] addr(input int kk, input logic [3:0] off);
    return 12'h100 + 12'(kk * 16) + {8'h00, off};
  endfunction

  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    @(posedge clock);
    while (wb_ack !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) err_count++;
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask

  task automatic setsig(input int kk, input int v);
    sigs[kk*16 +: 16] <= 16'(v);
  endtask

  task automatic wait_act(input int kk, input logic v);
    int n;
    n = 0;
    while (key_active[kk] !== v && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, key_active[kk]}, {31'h0, v});
  endtask

  // reference moves in steps, so poll a bounded number of reads
  task automatic poll_ref(input int kk, input int lim);
    logic [31:0] rd;
    int n;
    n = 0;
    wb(1'b0, addr(kk, 4'h8), 32'h0, rd);
    while (rd[15:0] !== 16'(ref_m[kk]) && n < lim) begin
      wb(1'b0, addr(kk, 4'h8), 32'h0, rd);
      n++;
    end
    chk({16'h0, rd[15:0]}, {16'h0, 16'(ref_m[kk])});
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    end_sim;
  end

  // ************************************
  // scenarios
  // ************************************
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 12'h000;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    delay = 4'h1;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h1bc1));
    for (k = 0; k < 4; k++) begin
      base[k] = 32'h2000 + ($urandom & 32'h0FFF);
      ref_m[k] = base[k];
      sigs[k*16 +: 16] = 16'(base[k]);
    end
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (k = 0; k < 4; k++) begin
      wb(1'b0, addr(k, 4'h0), 32'h0, q);
      chk(q, 32'h040A0206);
      wb(1'b0, addr(k, 4'h4), 32'h0, q);
      chk(q, 32'h06140502);
      poll_ref(k, 40);
    end
    wb(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b0, 12'hFFC, 32'h0, q);
    chk(q, 32'h0);
    delay <= 4'($urandom % 5);
    wb(1'b1, addr(2, 4'h0), 32'h040A0200, q);
    setsig(1, base[1] - 9);
    setsig(2, base[2] - 4);
    setsig(3, base[3] - 4);
    r0 = reps;
    wait_act(2, 1'b1);
    chk({31'h0, reps > r0}, 32'h1);
    chk({28'h0, key_active}, 32'h4);
    wb(1'b0, 12'h004, 32'h0, q);
    chk(q, 32'h4);
    setsig(1, base[1] - 10);
    wait_act(1, 1'b1);
    wb(1'b0, addr(1, 4'h8), 32'h0, q);
    chk({24'h0, q[31:24]}, 32'h2);
    poll_ref(1, 0);
    for (k = 1; k < 4; k++) setsig(k, base[k]);
    wait_act(1, 1'b0);
    wait_act(2, 1'b0);
    wb(1'b1, addr(0, 4'h4), 32'h06140102, q);
    delay <= 4'($urandom % 5);
    r0 = reps;
    setsig(0, base[0] - 20);
    wait_act(0, 1'b1);
    chk(32'(reps), 32'(r0));
    setsig(0, base[0]);
    wait_act(0, 1'b0);
    wb(1'b1, addr(3, 4'h4), 32'h06000502, q);
    setsig(3, base[3] - 20);
    wait_act(3, 1'b1);
    repeat (3000) @(posedge clock);
    chk({31'h0, key_active[3]}, 32'h1);
    wb(1'b1, addr(3, 4'h4), 32'h06010502, q);
    wait_act(3, 1'b0);
    ref_m[3] = base[3] - 20;
    poll_ref(3, 0);
    setsig(3, base[3] - 40);
    wait_act(3, 1'b1);
    wait_act(3, 1'b0);
    setsig(3, base[3]);
    ref_m[3] = base[3];
    poll_ref(3, 100);
    setsig(1, base[1] + 5);
    ref_m[1] = base[1] + 5;
    wb(1'b1, 12'h000, 32'h00000103, q);
    poll_ref(1, 30);
    wb(1'b0, 12'h000, 32'h0, q);
    chk(q, 32'h1);
    wb(1'b1, 12'h000, 32'h0, q);
    repeat (20) @(posedge clock);
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      chk({31'h0, burst_req}, 32'h0);
    end
    end_sim;
  end
endmodule
